// ### lcst_regs.sv
`timescale 1ns/1ps
`include "lcst_defines.svh"

module lcst_regs #(
  parameter int UNIT_PWM_CYCLES = `LCST_UNIT_PWM_A * `LCST_UNIT_PWM_B
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic         soft_rst,
  // register access from the serial interface
  input  lcst_pkg::lcst_req_t req,
  output lcst_pkg::lcst_rsp_t rsp,
  // selection register contents
  input  wire logic [7:0]   sel_reg,
  // per channel settings
  output lcst_pkg::lcst_chan_t ch1,
  output lcst_pkg::lcst_chan_t ch2,
  output lcst_pkg::lcst_chan_t ch3,
  // slope timebase
  output logic              pwm_tick,
  output logic              unit_tick
);

  logic [7:0] ch1_level_code;
  logic [7:0] ch2_level_code;
  logic [7:0] ch3_level_code;
  logic [7:0] ch1_slope_time_reg;
  logic [7:0] ch2_slope_time_reg;
  logic [1:0] current_range_sel;

  function automatic logic [15:0] lcst_current_ua(input logic [7:0] code, input logic [1:0] range);
    logic [15:0] step;
    step = `LCST_STEP_R1_UA;
    case (range)
      2'h0:    step = `LCST_STEP_R0_UA;
      2'h1:    step = `LCST_STEP_R1_UA;
      2'h2:    step = `LCST_STEP_R2_UA;
      2'h3:    step = `LCST_STEP_R3_UA;
      default: step = `LCST_STEP_R1_UA;
    endcase
    // 255 x 250 fits in 16 bits, so no overflow at the top range
    lcst_current_ua = 16'({8'h00, code} * step);
  endfunction

  function automatic logic [17:0] lcst_phase_pwm(input logic [3:0] code);
    lcst_phase_pwm = 18'({14'h0000, code} * 18'(UNIT_PWM_CYCLES));
  endfunction

  function automatic logic [3:0] lcst_nib(input logic [7:0] r, input int lsb);
    lcst_nib = r[lsb +: `LCST_NIB_W];
  endfunction

  // range field applies to every channel
  assign current_range_sel = sel_reg[`LCST_RANGE_MSB:`LCST_RANGE_LSB];

  // level registers, soft reset beats a same-cycle write
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ch1_level_code <= `LCST_LEVEL_RST;
      ch2_level_code <= `LCST_LEVEL_RST;
      ch3_level_code <= `LCST_LEVEL_RST;
    end else if (ce) begin
      if (soft_rst) begin
        ch1_level_code <= `LCST_LEVEL_RST;
        ch2_level_code <= `LCST_LEVEL_RST;
        ch3_level_code <= `LCST_LEVEL_RST;
      end else if (req.wr) begin
        if (req.addr == `LCST_ADDR_CH1_LEVEL) ch1_level_code <= req.wdata;
        if (req.addr == `LCST_ADDR_CH2_LEVEL) ch2_level_code <= req.wdata;
        if (req.addr == `LCST_ADDR_CH3_LEVEL) ch3_level_code <= req.wdata;
      end
    end
  end

  // slope total-time registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ch1_slope_time_reg <= `LCST_SLOPE_RST;
      ch2_slope_time_reg <= `LCST_SLOPE_RST;
    end else if (ce) begin
      if (soft_rst) begin
        ch1_slope_time_reg <= `LCST_SLOPE_RST;
        ch2_slope_time_reg <= `LCST_SLOPE_RST;
      end else if (req.wr) begin
        if (req.addr == `LCST_ADDR_CH1_SLOPE) ch1_slope_time_reg <= req.wdata;
        if (req.addr == `LCST_ADDR_CH2_SLOPE) ch2_slope_time_reg <= req.wdata;
      end
    end
  end

  // read port, unmapped addresses answer zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rsp <= '0;
    end else if (ce) begin
      rsp.valid <= req.rd;
      if (req.rd) begin
        case (req.addr)
          `LCST_ADDR_CH1_LEVEL: rsp.rdata <= ch1_level_code;
          `LCST_ADDR_CH2_LEVEL: rsp.rdata <= ch2_level_code;
          `LCST_ADDR_CH3_LEVEL: rsp.rdata <= ch3_level_code;
          `LCST_ADDR_CH1_SLOPE: rsp.rdata <= ch1_slope_time_reg;
          `LCST_ADDR_CH2_SLOPE: rsp.rdata <= ch2_slope_time_reg;
          default:              rsp.rdata <= 8'h00;
        endcase
      end
    end
  end

  // derived settings, one cycle behind the stored registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ch1 <= '0;
      ch2 <= '0;
      ch3 <= '0;
    end else if (ce) begin
      ch1.current_ua   <= lcst_current_ua(ch1_level_code, current_range_sel);
      ch2.current_ua   <= lcst_current_ua(ch2_level_code, current_range_sel);
      ch3.current_ua   <= lcst_current_ua(ch3_level_code, current_range_sel);
      ch1.phase12_code <= lcst_nib(ch1_slope_time_reg, `LCST_P12_LSB);
      ch1.phase34_code <= lcst_nib(ch1_slope_time_reg, `LCST_P34_LSB);
      ch1.phase12_pwm  <= lcst_phase_pwm(lcst_nib(ch1_slope_time_reg, `LCST_P12_LSB));
      ch1.phase34_pwm  <= lcst_phase_pwm(lcst_nib(ch1_slope_time_reg, `LCST_P34_LSB));
      // channel two decoded exactly as channel one
      ch2.phase12_code <= lcst_nib(ch2_slope_time_reg, `LCST_P12_LSB);
      ch2.phase34_code <= lcst_nib(ch2_slope_time_reg, `LCST_P34_LSB);
      ch2.phase12_pwm  <= lcst_phase_pwm(lcst_nib(ch2_slope_time_reg, `LCST_P12_LSB));
      ch2.phase34_pwm  <= lcst_phase_pwm(lcst_nib(ch2_slope_time_reg, `LCST_P34_LSB));
      // channel three has no slope register, so its slope fields are held at zero
      ch3.phase12_code <= 4'h0;
      ch3.phase34_code <= 4'h0;
      ch3.phase12_pwm  <= 18'h00000;
      ch3.phase34_pwm  <= 18'h00000;
    end
  end

  lcst_slope_tick #(
    .UNIT_PWM_CYCLES (UNIT_PWM_CYCLES)
  ) u_tick (
    .mclk      (mclk),
    .rstn      (rstn),
    .ce        (ce),
    .soft_rst  (soft_rst),
    .pwm_tick  (pwm_tick),
    .unit_tick (unit_tick)
  );

endmodule

// ### lcst_defines.svh
`ifndef LCST_DEFINES_SVH
`define LCST_DEFINES_SVH

// sub-addresses
`define LCST_ADDR_CH1_LEVEL  8'h03
`define LCST_ADDR_CH2_LEVEL  8'h04
`define LCST_ADDR_CH3_LEVEL  8'h05
`define LCST_ADDR_CH1_SLOPE  8'h06
`define LCST_ADDR_CH2_SLOPE  8'h07

// reset values
`define LCST_LEVEL_RST       8'h00
`define LCST_SLOPE_RST       8'h88
`define LCST_RANGE_RST       2'h1

// slope register fields
`define LCST_P12_LSB         0
`define LCST_P34_LSB         4
`define LCST_NIB_W           4

// selection register field holding the current range
`define LCST_RANGE_MSB       7
`define LCST_RANGE_LSB       6

// current step per range code, in microamps
`define LCST_STEP_R0_UA      16'h0032
`define LCST_STEP_R1_UA      16'h0064
`define LCST_STEP_R2_UA      16'h007D
`define LCST_STEP_R3_UA      16'h00FA

// timing
`define LCST_CLK_MHZ         20
`define LCST_PWM_CYCLE_US    53.3
`define LCST_UNIT_PWM_A      75
`define LCST_UNIT_PWM_B      125
`define LCST_UNIT_TIME_S     0.5

`endif

// ### lcst_pkg.sv
package lcst_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lcst_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } lcst_rsp_t;

  typedef struct packed {
    logic [15:0] current_ua;
    logic [3:0]  phase12_code;
    logic [3:0]  phase34_code;
    logic [17:0] phase12_pwm;
    logic [17:0] phase34_pwm;
  } lcst_chan_t;

  typedef enum logic {
    LCST_TICK_IDLE,
    LCST_TICK_RUN
  } lcst_tick_st_t;

endpackage

// ### lcst_slope_tick.sv
`timescale 1ns/1ps
`include "lcst_defines.svh"

module lcst_slope_tick #(
  parameter int UNIT_PWM_CYCLES = `LCST_UNIT_PWM_A * `LCST_UNIT_PWM_B
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic ce,
  input  wire logic soft_rst,
  // ticks
  output logic      pwm_tick,
  output logic      unit_tick
);

  // nearest whole clock count to one pwm cycle
  localparam int PWM_CYCLES = $rtoi(`LCST_PWM_CYCLE_US * `LCST_CLK_MHZ + 0.5);

  logic [10:0]          pwm_cnt_q;
  logic [17:0]          unit_cnt_q;
  lcst_pkg::lcst_tick_st_t st_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q <= lcst_pkg::LCST_TICK_IDLE;
    end else if (ce) begin
      case (st_q)
        lcst_pkg::LCST_TICK_IDLE: st_q <= lcst_pkg::LCST_TICK_RUN;
        lcst_pkg::LCST_TICK_RUN:  st_q <= soft_rst ? lcst_pkg::LCST_TICK_IDLE : lcst_pkg::LCST_TICK_RUN;
        default:                  st_q <= lcst_pkg::LCST_TICK_IDLE;
      endcase
    end
  end

  // pwm cycle timebase
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pwm_cnt_q <= 11'h000;
      pwm_tick  <= 1'b0;
    end else if (ce) begin
      if (soft_rst || st_q != lcst_pkg::LCST_TICK_RUN) begin
        pwm_cnt_q <= 11'h000;
        pwm_tick  <= 1'b0;
      end else if (pwm_cnt_q == 11'(PWM_CYCLES - 1)) begin
        pwm_cnt_q <= 11'h000;
        pwm_tick  <= 1'b1;
      end else begin
        pwm_cnt_q <= pwm_cnt_q + 11'h001;
        pwm_tick  <= 1'b0;
      end
    end
  end

  // one slope time unit is 75 x 125 pwm cycles
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      unit_cnt_q <= 18'h00000;
      unit_tick  <= 1'b0;
    end else if (ce) begin
      if (soft_rst || st_q != lcst_pkg::LCST_TICK_RUN) begin
        unit_cnt_q <= 18'h00000;
        unit_tick  <= 1'b0;
      end else if (pwm_tick && unit_cnt_q == 18'(UNIT_PWM_CYCLES - 1)) begin
        unit_cnt_q <= 18'h00000;
        unit_tick  <= 1'b1;
      end else if (pwm_tick) begin
        unit_cnt_q <= unit_cnt_q + 18'h00001;
        unit_tick  <= 1'b0;
      end else begin
        unit_tick  <= 1'b0;
      end
    end
  end

endmodule

// ### lcst_regs_assertions.sv
`timescale 1ns/1ps
module lcst_chk #(
  parameter int UNIT_PWM_CYCLES = 9375
) (
  // clock and reset
  input wire logic            mclk,
  input wire logic            rstn,
  input wire logic            ce,
  input wire logic            soft_rst,
  // register port
  input lcst_pkg::lcst_req_t  req,
  input lcst_pkg::lcst_rsp_t  rsp,
  input wire logic [7:0]      sel_reg,
  // derived outputs
  input lcst_pkg::lcst_chan_t ch1,
  input lcst_pkg::lcst_chan_t ch2,
  input wire logic            pwm_tick,
  input wire logic            unit_tick
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic [10:0] gap_q;
  logic        seen_q;
  function automatic logic [15:0] step(input logic [1:0] r);
    return r[1] ? (r[0] ? 16'h00FA : 16'h007D) : (r[0] ? 16'h0064 : 16'h0032);
  endfunction
  // soft reset restarts the timebase, so the first gap after it is not judged
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gap_q  <= 11'h000;
      seen_q <= 1'b0;
    end else if (ce) begin
      if (soft_rst) begin
        gap_q  <= 11'h000;
        seen_q <= 1'b0;
      end else begin
        gap_q  <= pwm_tick ? 11'h000 : gap_q + 11'h001;
        seen_q <= seen_q | pwm_tick;
      end
    end
  end
  rd_answer_a: assert property (ce && req.rd && !soft_rst |=> rsp.valid)
    else $error("read not answered");
  rd_cause_a: assert property (rsp.valid |-> $past(req.rd))
    else $error("answer without read");
  rdata_hold_a: assert property (!rsp.valid && !$past(soft_rst) |-> $stable(rsp.rdata))
    else $error("read data moved");
  lvl_current_a: assert property (ce && req.wr && req.addr == 8'h03 && !soft_rst ##1 ce
    |=> ch1.current_ua == 16'($past(req.wdata, 2)) * step($past(sel_reg[7:6]))) else $error("ch1 current wrong");
  slope_nib_a: assert property (ce && req.wr && req.addr == 8'h07 && !soft_rst ##1 ce
    |=> {ch2.phase34_code, ch2.phase12_code} == $past(req.wdata, 2)) else $error("ch2 nibbles wrong");
  pwm_scale_a: assert property (ch1.phase12_pwm == 18'(ch1.phase12_code) * UNIT_PWM_CYCLES
    && ch2.phase34_pwm == 18'(ch2.phase34_code) * UNIT_PWM_CYCLES) else $error("slope length wrong");
  pwm_gap_a: assert property (pwm_tick && seen_q |-> gap_q == 11'h429)
    else $error("pwm period wrong");
  unit_align_a: assert property (unit_tick |-> $past(pwm_tick))
    else $error("unit tick misplaced");
  ce_freeze_a: assert property (!ce |=> $stable(rsp) && $stable(ch1) && $stable(ch2) && $stable(pwm_tick))
    else $error("state moved while clock enable low");
  cover property (!ce ##1 ce);
  cover property (rsp.valid);
  cover property (unit_tick);
  cover property (soft_rst ##1 !soft_rst);
endmodule

bind lcst_regs lcst_chk #(.UNIT_PWM_CYCLES(UNIT_PWM_CYCLES)) lcst_chk_inst (
  .mclk, .rstn, .ce, .soft_rst, .req, .rsp, .sel_reg, .ch1, .ch2, .pwm_tick, .unit_tick);

// ### lcst_host.sv
`timescale 1ns/1ps
module lcst_host (
  // register port
  input wire logic            mclk,
  input lcst_pkg::lcst_rsp_t  rsp,
  output lcst_pkg::lcst_req_t req
);
  // idle bus carries zeros, never the last byte
  initial req = '0;
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    req <= '0;
  endtask
  task automatic read(input logic [7:0] a, output logic ok, output logic [7:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    req <= '0;
    #1;
    ok = rsp.valid;
    d = rsp.rdata;
  endtask
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int UNIT = 3;
  localparam logic [15:0] STEP [4] = '{16'h0032, 16'h0064, 16'h007D, 16'h00FA};
  logic                 mclk = 1'b0;
  logic                 rstn = 1'b0;
  logic                 soft_rst = 1'b0;
  logic                 ce = 1'b1;
  logic [7:0]           sel_reg = 8'h40;
  lcst_pkg::lcst_req_t  req;
  lcst_pkg::lcst_rsp_t  rsp;
  lcst_pkg::lcst_chan_t ch1, ch2, ch3;
  logic                 pwm_tick, unit_tick, ok;
  logic [7:0]           rd;
  int                   errors = 0;
  int                   n_tests = 0;
  initial forever #25 mclk = ~mclk;
  lcst_regs #(.UNIT_PWM_CYCLES(UNIT)) lcst_regs_inst (.mclk, .rstn, .ce, .soft_rst, .req, .rsp,
    .sel_reg, .ch1, .ch2, .ch3, .pwm_tick, .unit_tick);
  lcst_host lcst_host_inst (.mclk, .rsp, .req);
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    lcst_host_inst.read(a, ok, rd);
    chk("rsp valid", 18'h1, 18'(ok));
    chk($sformatf("reg %h", a), 18'(e), 18'(rd));
  endtask
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic t_reset();
    rchk(8'h03, 8'h00);
    rchk(8'h04, 8'h00);
    rchk(8'h05, 8'h00);
    rchk(8'h06, 8'h88);
    rchk(8'h07, 8'h88);
    chk("ch1 p12 code", 18'h8, 18'(ch1.phase12_code));
    chk("ch2 p34 pwm", 18'(8 * UNIT), ch2.phase34_pwm);
    chk("ch1 current", 18'h0, 18'(ch1.current_ua));
    $display("t_reset done");
  endtask
  task automatic t_rw();
    for (int i = 3; i < 9; i++) begin
      lcst_host_inst.write(8'(i), 8'(i) ^ 8'hA5);
      rchk(8'(i), (i < 8) ? 8'(i) ^ 8'hA5 : 8'h00);
    end
    $display("t_rw done");
  endtask
  task automatic t_range();
    lcst_host_inst.write(8'h05, 8'hFF);
    lcst_host_inst.write(8'h03, 8'h01);
    for (int r = 0; r < 4; r++) begin
      @(posedge mclk);
      sel_reg <= {2'(r), 6'h15};
      settle();
      chk("ch3 current", 18'(8'hFF * STEP[r]), 18'(ch3.current_ua));
      chk("ch2 current", 18'(8'hA1 * STEP[r]), 18'(ch2.current_ua));
      chk("ch1 current", 18'(STEP[r]), 18'(ch1.current_ua));
    end
    $display("t_range done");
  endtask
  task automatic t_slope();
    lcst_host_inst.write(8'h07, 8'hF0);
    lcst_host_inst.write(8'h06, 8'h1F);
    settle();
    chk("ch2 p12 pwm", 18'h0, ch2.phase12_pwm);
    chk("ch2 p34 pwm", 18'(15 * UNIT), ch2.phase34_pwm);
    chk("ch1 p12 pwm", 18'(15 * UNIT), ch1.phase12_pwm);
    chk("ch1 p34 code", 18'h1, 18'(ch1.phase34_code));
    chk("ch1 p34 pwm", 18'(1 * UNIT), ch1.phase34_pwm);
    chk("ch2 p12 code", 18'h0, 18'(ch2.phase12_code));
    chk("ch3 slope", 18'h0, ch3.phase12_pwm | ch3.phase34_pwm | 18'({ch3.phase34_code, ch3.phase12_code}));
    $display("t_slope done");
  endtask
  task automatic t_soft();
    fork
      lcst_host_inst.write(8'h03, 8'h77);
      begin
        @(posedge mclk);
        soft_rst <= 1'b1;
        @(posedge mclk);
        soft_rst <= 1'b0;
      end
    join
    rchk(8'h03, 8'h00);
    rchk(8'h06, 8'h88);
    $display("t_soft done");
  endtask
  task automatic t_ce();
    @(posedge mclk);
    ce <= 1'b0;
    lcst_host_inst.write(8'h04, 8'h5A);
    lcst_host_inst.read(8'h05, ok, rd);
    chk("rsp valid frozen", 18'h0, 18'(ok));
    @(posedge mclk);
    ce <= 1'b1;
    rchk(8'h04, 8'h00);
    $display("t_ce done");
  endtask
  task automatic gap(input bit u, output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
      if (n > 9000) begin
        errors++;
        end_of_test();
      end
    end while ((u ? unit_tick : pwm_tick) !== 1'b1);
  endtask
  task automatic t_tick();
    int n;
    gap(1'b0, n);
    gap(1'b0, n);
    chk("pwm period", 18'd1066, 18'(n));
    gap(1'b1, n);
    gap(1'b1, n);
    chk("unit period", 18'(UNIT * 1066), 18'(n));
    $display("t_tick done");
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_rw();
    t_range();
    t_slope();
    t_soft();
    t_ce();
    t_tick();
    end_of_test();
  end
endmodule
